// ### inc/imht_consts.vh
`ifndef IMHT_CONSTS_VH
`define IMHT_CONSTS_VH

// register offsets
`define IMHT_OFF_STATUS_ONE   8'h41
`define IMHT_OFF_STATUS_TWO   8'h42
`define IMHT_OFF_MASK_ONE     8'h74
`define IMHT_OFF_MASK_TWO     8'h75
`define IMHT_OFF_CONFIG_THREE 8'h78
`define IMHT_OFF_HOT_COUNT    8'h79
`define IMHT_OFF_HOT_LIMIT    8'h7a
`define IMHT_OFF_CONFIG_FOUR  8'h7d

// reset values
`define IMHT_RST_MASK_ONE     8'h00
`define IMHT_RST_MASK_TWO     8'h00
`define IMHT_RST_CONFIG_THREE 8'h00
`define IMHT_RST_HOT_LIMIT    8'h00
`define IMHT_RST_CONFIG_FOUR  8'h00

// configuration three fields
`define IMHT_C3_ALERT_EN      0
`define IMHT_C3_HOT_EN        1
`define IMHT_C3_FULL_SPEED    2
// configuration four fields
`define IMHT_C4_ALT_ALERT     0
`define IMHT_C4_HOT_PIN_SEL   1

// mask and status fields
`define IMHT_M1_SUMMARY       7
`define IMHT_S2_FOURTH_FAN_FAIL_OR_HOT   5

// timing
`define IMHT_CLK_PERIOD_NS    10
`define IMHT_HOT_TICK_NS      22760000

`endif

// ### rtl/imht_hot_timer.v
`timescale 1ns/10ps
`include "imht_consts.vh"

// accumulates hot-event assertion time in 22.76 ms units
module imht_hot_timer #(
	parameter integer TICK_CYCLES = `IMHT_HOT_TICK_NS / `IMHT_CLK_PERIOD_NS,
	parameter integer PRE_WIDTH   = 22
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       hot_active,
	input  wire       clear_rd,
	output wire [7:0] count_value
);

	localparam integer         PRE_LAST_FULL = TICK_CYCLES - 1;
	localparam [PRE_WIDTH-1:0] PRE_LAST      = PRE_LAST_FULL[PRE_WIDTH-1:0];

	reg [PRE_WIDTH-1:0] pre;
	reg [7:0]           ticks;
	reg                 seen;

	always @(posedge clk) begin
		if (!rst_n) begin
			pre   <= {PRE_WIDTH{1'b0}};
			ticks <= 8'h00;
			seen  <= 1'b0;
		end else if (clear_rd) begin
			// read clears; an ongoing assertion restarts at one
			pre   <= {PRE_WIDTH{1'b0}};
			ticks <= 8'h00;
			seen  <= hot_active;
		end else if (hot_active) begin
			seen <= 1'b1;
			if (ticks != 8'hff) begin
				if (pre == PRE_LAST) begin
					pre   <= {PRE_WIDTH{1'b0}};
					ticks <= ticks + 8'h01;
				end else begin
					pre <= pre + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// below two units only the first-assertion flag shows in bit 0
	assign count_value = (ticks >= 8'h02) ? ticks : {7'h00, seen};

endmodule // imht_hot_timer

// ### rtl/imht_top.v
`timescale 1ns/10ps
`include "imht_consts.vh"

module imht_top #(
	parameter integer FANS        = 3,
	parameter integer TICK_CYCLES = `IMHT_HOT_TICK_NS / `IMHT_CLK_PERIOD_NS
) (
	input  wire            SYS_CLK,
	input  wire            RST_N,
	input  wire [7:0]      REG_ADDR,
	input  wire [7:0]      REG_WDATA,
	input  wire            REG_WR,
	input  wire            REG_RD,
	output reg  [7:0]      REG_RDATA,
	input  wire [6:0]      STATUS_ONE_COND,
	input  wire [7:0]      STATUS_TWO_COND,
	input  wire            HOT_PIN_A_N,
	input  wire            HOT_PIN_B_N,
	input  wire [FANS-1:0] FAN_RUNNING,
	output reg  [FANS-1:0] FAN_FULL_SPEED,
	output reg             ALERT_A_OUT,
	output reg             ALERT_A_OE,
	output reg             ALERT_B_OUT,
	output reg             ALERT_B_OE
);

	function hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	// software registers
	reg [7:0] interrupt_mask_one;
	reg [7:0] interrupt_mask_two;
	reg [7:0] configuration_three;
	reg [7:0] hot_duration_limit;
	reg [7:0] configuration_four;

	// sticky status
	reg [6:0] status_one;
	reg [7:0] status_two;

	wire       rd_status_one;
	wire       rd_status_two;
	wire       rd_hot_count;
	wire       wr_mask_one;
	wire       wr_mask_two;
	wire       wr_config_three;
	wire       wr_hot_limit;
	wire       wr_config_four;

	assign rd_status_one   = REG_RD & hit(REG_ADDR, `IMHT_OFF_STATUS_ONE);
	assign rd_status_two   = REG_RD & hit(REG_ADDR, `IMHT_OFF_STATUS_TWO);
	assign rd_hot_count    = REG_RD & hit(REG_ADDR, `IMHT_OFF_HOT_COUNT);
	assign wr_mask_one     = REG_WR & hit(REG_ADDR, `IMHT_OFF_MASK_ONE);
	assign wr_mask_two     = REG_WR & hit(REG_ADDR, `IMHT_OFF_MASK_TWO);
	assign wr_config_three = REG_WR & hit(REG_ADDR, `IMHT_OFF_CONFIG_THREE);
	assign wr_hot_limit    = REG_WR & hit(REG_ADDR, `IMHT_OFF_HOT_LIMIT);
	assign wr_config_four  = REG_WR & hit(REG_ADDR, `IMHT_OFF_CONFIG_FOUR);

	// hot-event input selection
	wire hot_enable;
	wire hot_on_pin_b;
	wire hot_active;

	assign hot_enable   = configuration_three[`IMHT_C3_HOT_EN];
	assign hot_on_pin_b = configuration_four[`IMHT_C4_HOT_PIN_SEL];
	// only the selected pin is watched, never both
	assign hot_active   = hot_enable &
		(hot_on_pin_b ? ~HOT_PIN_B_N : ~HOT_PIN_A_N);

	// duration counter
	wire [7:0] hot_count;

	imht_hot_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.PRE_WIDTH   (22)
	) u_hot_timer (
		.clk         (SYS_CLK),
		.rst_n       (RST_N),
		.hot_active  (hot_active),
		.clear_rd    (rd_hot_count),
		.count_value (hot_count)
	);

	// limit comparison
	wire hot_over_limit;

	assign hot_over_limit = hot_enable & (hot_count > hot_duration_limit);

	// status two set conditions; bit 5 shared by fan four and hot
	wire [7:0] status_two_set;
	wire       fourth_fan_fail_fail_used;

	// fan four speed input is lost when it carries the hot event
	assign fourth_fan_fail_fail_used = ~(hot_enable & ~hot_on_pin_b);

	assign status_two_set[7:6] = STATUS_TWO_COND[7:6];
	assign status_two_set[5]   = (STATUS_TWO_COND[5] & fourth_fan_fail_fail_used) |
		hot_over_limit;
	assign status_two_set[4:0] = STATUS_TWO_COND[4:0];

	// sticky bits: a condition present in the read cycle wins
	genvar i;
	generate
		for (i = 0; i < 7; i = i + 1) begin : g_status_one
			always @(posedge SYS_CLK) begin
				if (!RST_N) begin
					status_one[i] <= 1'b0;
				end else if (STATUS_ONE_COND[i]) begin
					status_one[i] <= 1'b1;
				end else if (rd_status_one) begin
					status_one[i] <= 1'b0;
				end
			end
		end
		for (i = 0; i < 8; i = i + 1) begin : g_status_two
			always @(posedge SYS_CLK) begin
				if (!RST_N) begin
					status_two[i] <= 1'b0;
				end else if (status_two_set[i]) begin
					status_two[i] <= 1'b1;
				end else if (rd_status_two) begin
					status_two[i] <= 1'b0;
				end
			end
		end
	endgenerate

	wire status_two_summary;

	assign status_two_summary = |status_two;

	// register writes
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			interrupt_mask_one  <= `IMHT_RST_MASK_ONE;
			interrupt_mask_two  <= `IMHT_RST_MASK_TWO;
			configuration_three <= `IMHT_RST_CONFIG_THREE;
			hot_duration_limit  <= `IMHT_RST_HOT_LIMIT;
			configuration_four  <= `IMHT_RST_CONFIG_FOUR;
		end else begin
			if (wr_mask_one) begin
				interrupt_mask_one <= REG_WDATA;
			end
			if (wr_mask_two) begin
				interrupt_mask_two <= REG_WDATA;
			end
			if (wr_config_three) begin
				configuration_three <= REG_WDATA;
			end
			if (wr_hot_limit) begin
				hot_duration_limit <= REG_WDATA;
			end
			if (wr_config_four) begin
				configuration_four <= REG_WDATA;
			end
		end
	end

	// register reads, one cycle after the strobe
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			if (hit(REG_ADDR, `IMHT_OFF_STATUS_ONE)) begin
				REG_RDATA <= {status_two_summary, status_one};
			end else if (hit(REG_ADDR, `IMHT_OFF_STATUS_TWO)) begin
				REG_RDATA <= status_two;
			end else if (hit(REG_ADDR, `IMHT_OFF_MASK_ONE)) begin
				REG_RDATA <= interrupt_mask_one;
			end else if (hit(REG_ADDR, `IMHT_OFF_MASK_TWO)) begin
				REG_RDATA <= interrupt_mask_two;
			end else if (hit(REG_ADDR, `IMHT_OFF_CONFIG_THREE)) begin
				REG_RDATA <= configuration_three;
			end else if (hit(REG_ADDR, `IMHT_OFF_HOT_COUNT)) begin
				REG_RDATA <= hot_count;
			end else if (hit(REG_ADDR, `IMHT_OFF_HOT_LIMIT)) begin
				REG_RDATA <= hot_duration_limit;
			end else if (hit(REG_ADDR, `IMHT_OFF_CONFIG_FOUR)) begin
				REG_RDATA <= configuration_four;
			end else begin
				REG_RDATA <= 8'h00;
			end
		end
	end

	// alert request from unmasked status
	wire alert_from_one;
	wire alert_from_two;
	wire alert_request;

	assign alert_from_one = |(status_one & ~interrupt_mask_one[6:0]);
	// summary mask blocks every status-two source at once
	assign alert_from_two = (|(status_two & ~interrupt_mask_two)) &
		~interrupt_mask_one[`IMHT_M1_SUMMARY];
	// follows sticky status, so it holds until the read clears it
	assign alert_request  = alert_from_one | alert_from_two;

	// open-drain alert pins, pulled low only while enabled
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ALERT_A_OUT <= 1'b0;
			ALERT_A_OE  <= 1'b0;
			ALERT_B_OUT <= 1'b0;
			ALERT_B_OE  <= 1'b0;
		end else begin
			ALERT_A_OUT <= 1'b0;
			ALERT_B_OUT <= 1'b0;
			ALERT_A_OE  <= configuration_three[`IMHT_C3_ALERT_EN] &
				alert_request;
			ALERT_B_OE  <= configuration_four[`IMHT_C4_ALT_ALERT] &
				alert_request;
		end
	end

	// fan full-speed override
	wire full_speed_req;

	assign full_speed_req = configuration_three[`IMHT_C3_FULL_SPEED] & hot_active;

	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			FAN_FULL_SPEED <= {FANS{1'b0}};
		end else begin
			FAN_FULL_SPEED <= {FANS{full_speed_req}} & FAN_RUNNING;
		end
	end

endmodule // imht_top

// ### test/imht_chk.sv
`timescale 1ns/10ps
module imht_chk #(
	parameter integer FANS = 3
) (
	input wire            SYS_CLK,
	input wire            RST_N,
	input wire [7:0]      REG_ADDR,
	input wire            REG_RD,
	input wire [7:0]      REG_RDATA,
	input wire            HOT_PIN_A_N,
	input wire            HOT_PIN_B_N,
	input wire [FANS-1:0] FAN_RUNNING,
	input wire [FANS-1:0] FAN_FULL_SPEED,
	input wire            ALERT_A_OUT,
	input wire            ALERT_A_OE,
	input wire            ALERT_B_OUT,
	input wire            ALERT_B_OE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire rd_cnt = REG_RD && REG_ADDR == 8'h79;
	wire cool = HOT_PIN_A_N && HOT_PIN_B_N;
	a_reset_quiet:
		assert property ($rose(RST_N) |-> !ALERT_A_OE && !ALERT_B_OE && FAN_FULL_SPEED == 0)
		else $error("outputs active after reset");
	a_open_drain:
		assert property (ALERT_A_OUT == 1'b0 && ALERT_B_OUT == 1'b0)
		else $error("alert driven high");
	a_full_speed_override_needs_hot:
		assert property (FAN_FULL_SPEED != 0 |-> !$past(cool))
		else $error("full speed without hot input");
	a_full_speed_override_fan_run:
		assert property ((FAN_FULL_SPEED & ~$past(FAN_RUNNING)) == 0)
		else $error("full speed on stopped fan");
	a_rdata_holds:
		assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without read");
	a_clear_on_read:
		assert property (cool[*2] ##0 rd_cnt ##1 cool[*3] ##0 rd_cnt |=> REG_RDATA == 8'h00)
		else $error("counter not cleared by read");
	a_no_early_units:
		assert property (rd_cnt ##3 rd_cnt |=> REG_RDATA[7:1] == 7'h00)
		else $error("units before two ticks");
	a_restart_one:
		assert property (rd_cnt ##3 rd_cnt |=> REG_RDATA <= 8'h01)
		else $error("count after read above one");
endmodule // imht_chk

bind imht_top imht_chk #(.FANS(FANS)) chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
	.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.HOT_PIN_A_N(HOT_PIN_A_N), .HOT_PIN_B_N(HOT_PIN_B_N), .FAN_RUNNING(FAN_RUNNING),
	.FAN_FULL_SPEED(FAN_FULL_SPEED), .ALERT_A_OUT(ALERT_A_OUT), .ALERT_A_OE(ALERT_A_OE),
	.ALERT_B_OUT(ALERT_B_OUT), .ALERT_B_OE(ALERT_B_OE));

// ### test/imht_host.sv
`timescale 1ns/10ps
module imht_host (
	input  wire       clk,
	output reg  [7:0] addr,
	output reg  [7:0] wdata,
	output reg        wr,
	output reg        rd,
	input  wire [7:0] rdata
);
	initial {addr, wdata, wr, rd} = 18'h0;
	task wr_reg(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			addr <= ~a;
			wdata <= ~d;
		end
	endtask
	task rd_reg(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			addr <= ~a;
			@(posedge clk);
			d = rdata;
		end
	endtask
	// timer read, then status two read to clear the hot flag
	task rd_timer(output [7:0] d);
		reg [7:0] x;
		begin
			rd_reg(8'h79, d);
			rd_reg(8'h42, x);
		end
	endtask
endmodule // imht_host

// ### test/test_imht_top.sv
`timescale 1ns/10ps
module test_imht_top;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [6:0] s1 = 7'h00;
	reg  [7:0] s2 = 8'h00;
	reg        hot_a = 1'b1;
	reg        hot_b = 1'b1;
	reg  [2:0] run = 3'h0;
	wire [7:0] addr, wdata, rdata;
	wire       wr, rd, a_oe, b_oe;
	wire [2:0] fs;
	reg  [7:0] d;
	integer    errors = 0;
	integer    n_tests = 0;
	always #5 clk = ~clk;
	imht_top #(.FANS(3), .TICK_CYCLES(8)) dut_u (.SYS_CLK(clk), .RST_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.STATUS_ONE_COND(s1), .STATUS_TWO_COND(s2), .HOT_PIN_A_N(hot_a),
		.HOT_PIN_B_N(hot_b), .FAN_RUNNING(run), .FAN_FULL_SPEED(fs), .ALERT_A_OUT(),
		.ALERT_A_OE(a_oe), .ALERT_B_OUT(), .ALERT_B_OE(b_oe));
	imht_host host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	task chk(input [7:0] g, input [7:0] e);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task burst(input integer n);
		begin
			@(posedge clk) hot_a <= 1'b0;
			cyc(n);
			@(posedge clk) hot_a <= 1'b1;
			cyc(3);
		end
	endtask
	task t_reg;
		integer i;
		reg [63:0] offs;
		begin
			offs = 64'h74_75_78_79_7a_7d_41_00;
			for (i = 0; i < 8; i = i + 1) begin
				host_u.rd_reg(offs[8*i +: 8], d);
				chk(d, 8'h00);
			end
			chk(a_oe | b_oe, 8'h00);
			$display("t_reg done");
		end
	endtask
	task t_mask;
		begin
			@(posedge clk) s1 <= 7'h01;
			host_u.wr_reg(8'h78, 8'h01);
			cyc(3);
			chk({a_oe, b_oe}, 8'h02);
			host_u.wr_reg(8'h74, 8'h01);
			cyc(3);
			chk(a_oe, 8'h00);
			host_u.rd_reg(8'h41, d);
			chk(d, 8'h01);
			host_u.wr_reg(8'h7d, 8'h01);
			host_u.wr_reg(8'h74, 8'h80);
			@(posedge clk) s1 <= 7'h00;
			cyc(3);
			chk({a_oe, b_oe}, 8'h03);
			host_u.rd_reg(8'h41, d);
			chk(d, 8'h01);
			cyc(3);
			chk(a_oe, 8'h00);
			host_u.rd_reg(8'h41, d);
			chk(d, 8'h00);
			host_u.wr_reg(8'h74, 8'h00);
			host_u.wr_reg(8'h7d, 8'h00);
			$display("t_mask done");
		end
	endtask
	task t_hot;
		begin
			host_u.wr_reg(8'h78, 8'h07);
			@(posedge clk) run <= 3'h5;
			@(posedge clk) hot_a <= 1'b0;
			cyc(3);
			chk(fs, 8'h05);
			cyc(4);
			chk(a_oe, 8'h01);
			cyc(6);
			@(posedge clk) hot_a <= 1'b1;
			cyc(3);
			chk(fs, 8'h00);
			burst(13);
			host_u.rd_timer(d);
			chk(d, 8'h03);
			host_u.rd_reg(8'h79, d);
			chk(d, 8'h00);
			burst(4);
			host_u.rd_reg(8'h79, d);
			chk(d, 8'h01);
			@(posedge clk) hot_a <= 1'b0;
			host_u.rd_reg(8'h79, d);
			host_u.rd_reg(8'h79, d);
			chk(d, 8'h01);
			@(posedge clk) hot_a <= 1'b1;
			$display("t_hot done");
		end
	endtask
	task t_limit;
		begin
			host_u.wr_reg(8'h7a, 8'h01);
			host_u.rd_timer(d);
			cyc(3);
			chk(a_oe, 8'h00);
			burst(13);
			chk(a_oe, 8'h00);
			burst(13);
			chk(a_oe, 8'h01);
			host_u.rd_reg(8'h42, d);
			chk(d, 8'h20);
			host_u.rd_reg(8'h41, d);
			chk(d, 8'h80);
			host_u.wr_reg(8'h75, 8'h20);
			cyc(3);
			chk(a_oe, 8'h00);
			host_u.rd_timer(d);
			chk(d, 8'h03);
			host_u.rd_reg(8'h42, d);
			chk(d, 8'h00);
			host_u.wr_reg(8'h75, 8'h00);
			host_u.wr_reg(8'h7a, 8'h00);
			@(posedge clk) hot_a <= 1'b0;
			host_u.rd_timer(d);
			host_u.rd_reg(8'h42, d);
			chk(d, 8'h20);
			@(posedge clk) hot_a <= 1'b1;
			host_u.rd_timer(d);
			host_u.rd_reg(8'h42, d);
			chk(d, 8'h00);
			host_u.rd_reg(8'h79, d);
			host_u.rd_reg(8'h79, d);
			chk(d, 8'h00);
			$display("t_limit done");
		end
	endtask
	task t_two;
		begin
			host_u.wr_reg(8'h7d, 8'h02);
			@(posedge clk) hot_b <= 1'b0;
			cyc(3);
			chk(fs, 8'h05);
			@(posedge clk) hot_b <= 1'b1;
			@(posedge clk) hot_a <= 1'b0;
			cyc(3);
			chk(fs, 8'h00);
			@(posedge clk) hot_a <= 1'b1;
			host_u.rd_timer(d);
			chk(d, 8'h01);
			@(posedge clk) s2 <= 8'h20;
			cyc(3);
			chk(a_oe, 8'h01);
			host_u.wr_reg(8'h74, 8'h80);
			cyc(3);
			chk(a_oe, 8'h00);
			@(posedge clk) s2 <= 8'h00;
			host_u.rd_reg(8'h42, d);
			chk(d, 8'h20);
			host_u.wr_reg(8'h74, 8'h00);
			host_u.wr_reg(8'h75, 8'h01);
			@(posedge clk) s2 <= 8'h01;
			cyc(3);
			chk(a_oe, 8'h00);
			@(posedge clk) s2 <= 8'h00;
			host_u.rd_reg(8'h42, d);
			chk(d, 8'h01);
			host_u.wr_reg(8'h75, 8'h00);
			host_u.wr_reg(8'h7d, 8'h00);
			@(posedge clk) s2 <= 8'h20;
			cyc(3);
			chk(a_oe, 8'h00);
			@(posedge clk) s2 <= 8'h00;
			host_u.rd_reg(8'h42, d);
			chk(d, 8'h00);
			$display("t_two done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", n_tests, errors);
			if (errors == 0 && n_tests > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		errors = errors + 1;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reg;
		t_mask;
		t_hot;
		t_limit;
		t_two;
		tally_and_finish;
	end
endmodule // test_imht_top
